/* hdl/ttc_consts.svh */
// Constants for the thermal assertion timer and tach configuration block
// Functional notes
// (RULE1) Fast bit gives one tach measurement per 250 ms
// (RULE2) Continuous bit measures tach regardless of drive
// (RULE3) Continuous bit disables pulse stretching for that fan
// (RULE4) Lock bit makes tach config register read-only
// (RULE5) Status bits 7:1 read zero below 45.52 ms
// (RULE6) Status bit 0 set on assertion, read-clears
// (RULE7) Past 45.52 ms bit 0 is timer LSB
// (RULE8) Elapsed time counts 22.76 ms steps to 5.82 s
// (RULE9) Limit register holds 8-bit duration, 22.76 ms steps
// (RULE10) Time over limit sets thermal limit flag
// (RULE11) Zero limit flags immediately on assertion
// (RULE12) Status and limit registers reset to 0x00
// (RULE13) Pulses-per-revolution register resets to 0x55
// (RULE14) Pulse field code n counts n+1 pulses
// (RULE15) Timer runs only while asserted, saturates
`ifndef TTC_CONSTS_SVH
`define TTC_CONSTS_SVH

`define TTC_ADDR_STATUS     8'h79
`define TTC_ADDR_LIMIT      8'h7A
`define TTC_ADDR_PPR        8'h7B
`define TTC_ADDR_CFG        8'h7E

`define TTC_RST_STATUS      8'h00
`define TTC_RST_LIMIT       8'h00
`define TTC_RST_PPR         8'h55
`define TTC_RST_CFG         8'h00

`define TTC_CFG_FAST_BIT    3
`define TTC_CFG_DC_LSB      4

`define TTC_CNT_FULL        8'hFF
`define TTC_CNT_REPORT_MIN  8'h02

`define TTC_CLK_HZ          200000000
`define TTC_STEP_US         22760
`define TTC_FAST_MS         250
`define TTC_SLOW_MS         1000
`define TTC_STEP_CYC        ((`TTC_CLK_HZ / 1000000) * `TTC_STEP_US)
`define TTC_FAST_CYC        ((`TTC_CLK_HZ / 1000) * `TTC_FAST_MS)
`define TTC_SLOW_CYC        ((`TTC_CLK_HZ / 1000) * `TTC_SLOW_MS)

`endif

/* hdl/ttc_pkg.sv */
// Types for the thermal assertion timer and tach configuration block
package ttc_pkg;
  typedef enum logic [0:0] {
    TTC_IDLE = 1'b0,
    TTC_RUN  = 1'b1
  } ttc_state_t;
endpackage

/* hdl/ttc_top.sv */
// Thermal assertion timer, timer limit and tach configuration registers
`timescale 1ns/1ps
`include "ttc_consts.svh"
module ttc_top #(
  parameter int unsigned STEP_CYC = `TTC_STEP_CYC,
  parameter int unsigned FAST_CYC = `TTC_FAST_CYC,
  parameter int unsigned SLOW_CYC = `TTC_SLOW_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       config_lock_i,
  input  wire logic       thermal_overload_pin_i,
  input  wire logic       limit_flag_clr_i,
  output logic            thermal_limit_flag_o,
  input  wire logic [3:0] fan_drive_on_i,
  output logic      [3:0] tach_gate_o,
  output logic      [3:0] pulse_stretch_en_o,
  output logic            tach_measure_tick_o,
  output logic [3:0][2:0] pulses_per_meas_o
);

  ttc_pkg::ttc_state_t state;
  ttc_pkg::ttc_state_t next_state;
  logic [7:0]  elapsed_time_bits;
  logic [7:0]  next_elapsed_time_bits;
  logic        assert_seen_lsb;
  logic        next_assert_seen_lsb;
  logic [31:0] step_cnt;
  logic [31:0] next_step_cnt;
  logic [7:0]  assert_duration_limit;
  logic [7:0]  next_assert_duration_limit;
  logic [7:0]  ppr;
  logic [7:0]  next_ppr;
  logic [7:0]  cfg;
  logic [7:0]  next_cfg;
  logic [31:0] meas_cnt;
  logic [31:0] next_meas_cnt;
  logic        next_flag;
  logic        next_tick;
  logic [7:0]  next_rdata;
  logic [3:0]  next_gate;
  logic [3:0]  next_stretch;
  logic [3:0][2:0] next_ppm;
  logic        rise;
  logic        rd_status;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [7:0] status_view(input logic [7:0] cnt,
                                             input logic       seen);
    // Short assertions only report the seen bit
    if (cnt >= `TTC_CNT_REPORT_MIN) begin // [RULE5] [RULE7]
      status_view = cnt;
    end else begin
      status_view = {7'h00, seen};
    end
  endfunction

  assign rise      = (state == ttc_pkg::TTC_IDLE) && thermal_overload_pin_i;
  assign rd_status = reg_rd_i && hit(reg_addr_i, `TTC_ADDR_STATUS);

  always_comb begin
    next_state = thermal_overload_pin_i ? ttc_pkg::TTC_RUN
                                        : ttc_pkg::TTC_IDLE;
    next_step_cnt          = step_cnt;
    next_elapsed_time_bits = elapsed_time_bits;
    next_assert_seen_lsb   = assert_seen_lsb;
    // Residual step count is kept so short pulses still add up
    if (thermal_overload_pin_i) begin // [RULE15]
      if (step_cnt >= STEP_CYC - 1) begin
        next_step_cnt = 32'h0000_0000;
        if (elapsed_time_bits != `TTC_CNT_FULL) begin // [RULE8] [RULE15]
          next_elapsed_time_bits = elapsed_time_bits + 8'h01;
        end
      end else begin
        next_step_cnt = step_cnt + 32'h0000_0001;
      end
    end
    if (rd_status) begin // [RULE6]
      next_assert_seen_lsb   = 1'b0;
      next_elapsed_time_bits = 8'h00;
    end
    // A new assertion beats a read in the same cycle
    if (rise) begin // [RULE6]
      next_assert_seen_lsb = 1'b1;
    end
  end

  always_comb begin
    next_assert_duration_limit = assert_duration_limit;
    next_ppr = ppr;
    next_cfg = cfg;
    if (reg_wr_i && hit(reg_addr_i, `TTC_ADDR_LIMIT)) begin // [RULE9]
      next_assert_duration_limit = reg_wdata_i;
    end
    if (reg_wr_i && hit(reg_addr_i, `TTC_ADDR_PPR)) begin
      next_ppr = reg_wdata_i;
    end
    if (reg_wr_i && hit(reg_addr_i, `TTC_ADDR_CFG)
        && !config_lock_i) begin // [RULE4]
      next_cfg = reg_wdata_i;
    end
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `TTC_ADDR_STATUS: begin
          next_rdata = status_view(elapsed_time_bits, assert_seen_lsb);
        end
        `TTC_ADDR_LIMIT: begin
          next_rdata = assert_duration_limit;
        end
        `TTC_ADDR_PPR: begin
          next_rdata = ppr;
        end
        `TTC_ADDR_CFG: begin
          next_rdata = cfg;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always_comb begin
    next_flag = thermal_limit_flag_o;
    if (limit_flag_clr_i) begin
      next_flag = 1'b0;
    end
    if (elapsed_time_bits > assert_duration_limit) begin // [RULE10]
      next_flag = 1'b1;
    end
    if (rise && (assert_duration_limit == 8'h00)) begin // [RULE11]
      next_flag = 1'b1;
    end
    next_tick     = 1'b0;
    next_meas_cnt = meas_cnt + 32'h0000_0001;
    if (cfg[`TTC_CFG_FAST_BIT]) begin // [RULE1]
      if (meas_cnt >= FAST_CYC - 1) begin
        next_meas_cnt = 32'h0000_0000;
        next_tick     = 1'b1;
      end
    end else if (meas_cnt >= SLOW_CYC - 1) begin
      next_meas_cnt = 32'h0000_0000;
      next_tick     = 1'b1;
    end
  end

  for (genvar f = 0; f < 4; f++) begin : g_fan
    always_comb begin
      next_gate[f] = cfg[`TTC_CFG_DC_LSB + f]
                     | fan_drive_on_i[f]; // [RULE2]
      next_stretch[f] = ~cfg[`TTC_CFG_DC_LSB + f]; // [RULE3]
      next_ppm[f] = {1'b0, ppr[2*f +: 2]} + 3'h1; // [RULE14]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      state                 <= ttc_pkg::TTC_IDLE;
      step_cnt              <= 32'h0000_0000;
      elapsed_time_bits     <= `TTC_RST_STATUS; // [RULE12]
      assert_seen_lsb       <= 1'b0;
      assert_duration_limit <= `TTC_RST_LIMIT; // [RULE12]
      ppr                   <= `TTC_RST_PPR; // [RULE13]
      cfg                   <= `TTC_RST_CFG;
      meas_cnt              <= 32'h0000_0000;
      reg_rdata_o           <= 8'h00;
      thermal_limit_flag_o  <= 1'b0;
      tach_measure_tick_o   <= 1'b0;
      tach_gate_o           <= 4'h0;
      pulse_stretch_en_o    <= 4'hF;
      pulses_per_meas_o     <= '0;
    end else begin
      state                 <= next_state;
      step_cnt              <= next_step_cnt;
      elapsed_time_bits     <= next_elapsed_time_bits;
      assert_seen_lsb       <= next_assert_seen_lsb;
      assert_duration_limit <= next_assert_duration_limit;
      ppr                   <= next_ppr;
      cfg                   <= next_cfg;
      meas_cnt              <= next_meas_cnt;
      reg_rdata_o           <= next_rdata;
      thermal_limit_flag_o  <= next_flag;
      tach_measure_tick_o   <= next_tick;
      tach_gate_o           <= next_gate;
      pulse_stretch_en_o    <= next_stretch;
      pulses_per_meas_o     <= next_ppm;
    end
  end

  property p_lock;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (config_lock_i && reg_wr_i && hit(reg_addr_i, `TTC_ADDR_CFG))
      |=> (cfg == $past(cfg));
  endproperty
  a_lock: assert property (p_lock) else $error("cfg changed"); // [RULE4]

  property p_stretch;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    nrst_i |=> (pulse_stretch_en_o == ~$past(cfg[7:4]));
  endproperty
  a_stretch: assert property (p_stretch) else $error("bad stretch"); // [RULE3]

  property p_gate;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    nrst_i |=> (tach_gate_o == ($past(cfg[7:4]) | $past(fan_drive_on_i)));
  endproperty
  a_gate: assert property (p_gate) else $error("tach gate wrong"); // [RULE2]

  property p_upper;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_status && elapsed_time_bits < 8'h02) |=> (reg_rdata_o[7:1] == 7'h00);
  endproperty
  a_upper: assert property (p_upper) else $error("bits 7:1 set"); // [RULE5]

  property p_seen;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rise |=> assert_seen_lsb ##1 (assert_seen_lsb || $past(rd_status));
  endproperty
  a_seen: assert property (p_seen) else $error("seen bit not set"); // [RULE6]

  property p_clear;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_status && !rise) |=> !assert_seen_lsb;
  endproperty
  a_clear: assert property (p_clear) else $error("seen stuck"); // [RULE6]

  property p_sat;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (elapsed_time_bits == 8'hFF && !rd_status)
      |=> (elapsed_time_bits == 8'hFF);
  endproperty
  a_sat: assert property (p_sat) else $error("timer wrapped"); // [RULE15]

  property p_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !thermal_overload_pin_i
      |=> (elapsed_time_bits <= $past(elapsed_time_bits));
  endproperty
  a_hold: assert property (p_hold) else $error("timer ran idle"); // [RULE15]

  property p_imm;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rise && assert_duration_limit == 8'h00) |=> thermal_limit_flag_o;
  endproperty
  a_imm: assert property (p_imm) else $error("no immediate flag"); // [RULE11]

  property p_limit;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (elapsed_time_bits > assert_duration_limit) |=> thermal_limit_flag_o;
  endproperty
  a_limit: assert property (p_limit) else $error("flag missed"); // [RULE10]

  property p_ppm;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    nrst_i |=> (pulses_per_meas_o[0] == {1'b0, $past(ppr[1:0])} + 3'h1);
  endproperty
  a_ppm: assert property (p_ppm) else $error("pulse count wrong"); // [RULE14]

endmodule

/* verif/test_thermal_assert_timer_tach_cfg.sv */
// Self-checking bench for the thermal timer and tach config block
`timescale 1ns/1ps
module test_thermal_assert_timer_tach_cfg;
  typedef struct {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } ttc_row_t;
  logic            ref_clk_i = 1'b0;
  logic            nrst_i    = 1'b0;
  logic [7:0]      addr;
  logic            wr;
  logic            rd;
  logic [7:0]      wdata;
  logic            lock;
  logic            clr;
  logic [7:0]      rdata;
  logic            pin;
  logic            flag;
  logic [3:0]      drive;
  logic [3:0]      gate;
  logic [3:0]      stretch;
  logic            tick;
  logic [3:0][2:0] ppm;
  int              errors      = 0;
  int              check_count = 0;
  int              n;
  // Status writes and unmapped places must read back zero
  ttc_row_t        rows [5] = '{'{8'h7A, 8'h12, 8'h12},
    '{8'h7B, 8'hE4, 8'hE4}, '{8'h7E, 8'hF8, 8'hF8},
    '{8'h79, 8'hFF, 8'h00}, '{8'h10, 8'hAA, 8'h00}};

  always #2.5 ref_clk_i = ~ref_clk_i;

  ttc_far_side_model u_ttc_far_side_model (
    .clk_i      (ref_clk_i),
    .overload_o (pin),
    .drive_o    (drive)
  );

  // Short counts keep the run brief
  ttc_top #(.STEP_CYC(10), .FAST_CYC(20), .SLOW_CYC(40)) u_ttc_top (
    .ref_clk_i              (ref_clk_i),
    .nrst_i                 (nrst_i),
    .reg_addr_i             (addr),
    .reg_wr_i               (wr),
    .reg_rd_i               (rd),
    .reg_wdata_i            (wdata),
    .reg_rdata_o            (rdata),
    .config_lock_i          (lock),
    .thermal_overload_pin_i (pin),
    .limit_flag_clr_i       (clr),
    .thermal_limit_flag_o   (flag),
    .fan_drive_on_i         (drive),
    .tach_gate_o            (gate),
    .pulse_stretch_en_o     (stretch),
    .tach_measure_tick_o    (tick),
    .pulses_per_meas_o      (ppm)
  );

  task automatic check(input string nm, input logic [11:0] s,
                       input logic [11:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 check("rdata", {4'h0, rdata}, {4'h0, e});
  endtask

  task automatic tick_gap(input int e);
    n = 0;
    while (tick !== 1'b1 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (tick !== 1'b1 && n < 100);
    check("tick gap", 12'(n), 12'(e));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    tally_and_finish();
  end

  initial begin
    addr  <= 8'h00;
    wr    <= 1'b0;
    rd    <= 1'b0;
    wdata <= 8'h00;
    lock  <= 1'b0;
    clr   <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd_chk(8'h79, 8'h00);
    rd_chk(8'h7A, 8'h00);
    rd_chk(8'h7B, 8'h55);
    check("ppm", ppm, {4{3'd2}});
    check("stretch", {8'h0, stretch}, 12'h00F);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].r);
    end
    check("ppm", ppm, {3'd4, 3'd3, 3'd2, 3'd1});
    check("gate", {8'h0, gate}, 12'h00F);
    check("stretch", {8'h0, stretch}, 12'h000);
    tick_gap(20);
    @(posedge ref_clk_i);
    lock <= 1'b1;
    wr_reg(8'h7E, 8'h00);
    rd_chk(8'h7E, 8'hF8);
    @(posedge ref_clk_i);
    lock <= 1'b0;
    u_ttc_far_side_model.set_drive(4'h5);
    wr_reg(8'h7E, 8'h00);
    repeat (2) @(negedge ref_clk_i);
    check("gate", {8'h0, gate}, 12'h005);
    check("stretch", {8'h0, stretch}, 12'h00F);
    tick_gap(40);
    wr_reg(8'h7A, 8'h00);
    u_ttc_far_side_model.assert_for(1);
    @(negedge ref_clk_i);
    check("flag", {11'h0, flag}, 12'h001);
    rd_chk(8'h79, 8'h01);
    rd_chk(8'h79, 8'h00);
    @(posedge ref_clk_i);
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
    wr_reg(8'h7A, 8'h03);
    u_ttc_far_side_model.assert_for(15);
    repeat (2) @(negedge ref_clk_i);
    check("flag", {11'h0, flag}, 12'h000);
    rd_chk(8'h79, 8'h01);
    u_ttc_far_side_model.assert_for(50);
    repeat (2) @(negedge ref_clk_i);
    check("flag", {11'h0, flag}, 12'h001);
    rd_chk(8'h79, 8'h05);
    u_ttc_far_side_model.assert_for(3000);
    rd_chk(8'h79, 8'hFF);
    repeat (30) @(posedge ref_clk_i);
    rd_chk(8'h79, 8'h00);
    // Reset in mid-run must restore the limit
    wr_reg(8'h7A, 8'h44);
    nrst_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd_chk(8'h7A, 8'h00);
    tally_and_finish();
  end
endmodule

/* verif/ttc_far_side_model.sv */
// Far-side model: overload source and fan drive levels
`timescale 1ns/1ps
module ttc_far_side_model (
  input  wire logic       clk_i,
  output logic            overload_o,
  output logic      [3:0] drive_o
);
  initial begin
    overload_o = 1'b0;
    drive_o    = 4'h0;
  end
  // High for exactly n sampling edges, so step counts are exact
  task automatic assert_for(input int n);
    @(posedge clk_i);
    overload_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    overload_o <= 1'b0;
  endtask
  // Drive levels change as soon as the task is called, without waiting for a clock edge
  task automatic set_drive(input logic [3:0] d);
    drive_o <= d;
  endtask
endmodule
